// >>> bench/tlip_core_model.sv
// Purpose: Behavioural processor core facing the interrupt unit's vector port.
// Assumes: Core accepts a vector command in any cycle; return is requested by the bench.
// Notes:   Program counter advances every cycle so each push carries a distinct address.

`timescale 1ns/1ns

module tlip_core_model
   import tlip_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire tlip_core_s  coreCmd,
   input  wire logic        retReq,
   output logic [20:0]      returnAddr,
   output logic             returnFromIrq,
   output logic [20:0]      lastVec,
   output int               takeCount,
   output int               pushBad
);
   logic [20:0] pcPrev;

   // ==========================================================================
   // Program counter and return instruction
   // ==========================================================================
   // A moving address exposes a push taken from the wrong cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         returnAddr    <= 21'h000100;
         pcPrev        <= 21'h000000;
         returnFromIrq <= 1'b0;
      end else begin
         pcPrev        <= returnAddr;
         returnAddr    <= returnAddr + 21'h000001;
         returnFromIrq <= retReq;  // One-cycle pulse, bench spaces the requests
      end
   end

   // ==========================================================================
   // Vector command capture
   // ==========================================================================
   // Push and load must pair, and the pushed address is the one seen when deciding
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lastVec   <= 21'h000000;
         takeCount <= 0;
         pushBad   <= 0;
      end else if (coreCmd.load || coreCmd.push) begin
         lastVec   <= coreCmd.loadAddr;
         takeCount <= takeCount + 1;
         if (!(coreCmd.load && coreCmd.push) || coreCmd.pushAddr !== pcPrev) begin
            pushBad <= pushBad + 1;
         end
      end
   end
endmodule // tlip_core_model

// >>> bench/tlip_unit_tb.sv
// Purpose: Self-checking bench for the two-level interrupt priority unit.
// Assumes: Register port driven at rising edges; core modelled by tlip_core_model.
// Notes:   Software side clears flags before re-enabling and uses plain writes only.

`timescale 1ns/1ns

module tlip_unit_tb;
   import tlip_pkg::*;

   logic        clk_sys;
   logic        rst;
   tlip_bus_s   busReq;
   logic [7:0]  rdData;
   logic        timerZeroOvf;
   logic        extPinZero;
   logic [3:0]  upperPortPins;
   logic [7:0]  periphEvent;
   logic [20:0] returnAddr;
   logic        returnFromIrq;
   tlip_core_s  coreCmd;
   logic        retReq;
   logic [20:0] lastVec;
   int          takeCount;
   int          pushBad;
   int          mismatches;
   int          comparisons;
   int          n;
   int          base;

   // ==========================================================================
   // Clock, reset and instances
   // ==========================================================================
   // 10 MHz instruction clock
   always #50 clk_sys = ~clk_sys;

   tlip_unit #(.NPERIPH(8)) uut (
      .clk_sys(clk_sys), .rst(rst), .busReq(busReq), .rdData(rdData), .timerZeroOvf(timerZeroOvf),
      .extPinZero(extPinZero), .upperPortPins(upperPortPins), .periphEvent(periphEvent),
      .returnAddr(returnAddr), .returnFromIrq(returnFromIrq), .coreCmd(coreCmd));

   tlip_core_model core (
      .clk_sys(clk_sys), .rst(rst), .coreCmd(coreCmd), .retReq(retReq), .returnAddr(returnAddr),
      .returnFromIrq(returnFromIrq), .lastVec(lastVec), .takeCount(takeCount), .pushBad(pushBad));

   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] time %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe, a gap cycle follows so strobes never merge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys) busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys) busReq.wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys) busReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys) busReq.rd <= 1'b0;
      #1 chk(rdData, exp);
   endtask

   task automatic ret_irq();
      @(posedge clk_sys) retReq <= 1'b1;
      @(posedge clk_sys) retReq <= 1'b0;
   endtask

   // Bounded wait for the vector command; counts edges from the caller's point
   task automatic wait_take(output int cnt);
      cnt = 0;
      while (coreCmd.load !== 1'b1 && cnt < 12) begin
         @(posedge clk_sys);
         #1 cnt++;
      end
      chk(coreCmd.load, 1'b1);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset_map();
      rd_chk(OFF_ICR, RST_ICR);
      rd_chk(OFF_RCR, RST_RCR);
      rd_chk(OFF_CFG, RST_CFG);
      rd_chk(OFF_PPRI, RST_PPRI);
      wr(4'h9, 8'hFF);
      rd_chk(4'h9, 8'h00);
      $display("reset and map done");
   endtask

   // Pin event in compatibility mode: latency, vector, enable cleared, return
   task automatic t_pin_compat();
      base = takeCount;
      wr(OFF_ICR, 8'h90);
      @(posedge clk_sys) extPinZero <= 1'b1;
      #1 wait_take(n);
      chk(n == 3 || n == 4, 1'b1);
      chk(coreCmd.loadAddr, VEC_HIGH);
      rd_chk(OFF_ICR, 8'h12);
      wr(OFF_ICR, 8'h10);
      ret_irq();
      rd_chk(OFF_ICR, 8'h90);
      chk(takeCount - base, 1);
      // Falling edge select must flag the pin going low, with vectoring off
      wr(OFF_ICR, 8'h00);
      wr(OFF_CFG, 8'h07);
      @(posedge clk_sys) extPinZero <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rd_chk(OFF_ICR, 8'h02);
      wr(OFF_ICR, 8'h00);
      wr(OFF_CFG, RST_CFG);
      $display("pin compat done");
   endtask

   // Flag sets with bit 7 clear, no vector; setting bit 7 then vectors at once
   task automatic t_poll_flag();
      base = takeCount;
      wr(OFF_ICR, 8'h20);
      @(posedge clk_sys) timerZeroOvf <= 1'b1;
      @(posedge clk_sys) timerZeroOvf <= 1'b0;
      rd_chk(OFF_ICR, 8'h24);
      rd_chk(OFF_ICR, 8'h24);
      chk(takeCount - base, 0);
      wr(OFF_ICR, 8'hA4);
      #1 wait_take(n);
      chk(coreCmd.loadAddr, VEC_HIGH);
      wr(OFF_ICR, 8'h00);
      $display("poll flag done");
   endtask

   // Peripheral gate in compatibility mode; priority bits have no effect
   task automatic t_periph_gate();
      base = takeCount;
      wr(OFF_PPRI, 8'h00);
      wr(OFF_PEN, 8'h01);
      wr(OFF_ICR, 8'h80);
      @(posedge clk_sys) periphEvent <= 8'h01;
      @(posedge clk_sys) periphEvent <= 8'h00;
      rd_chk(OFF_PFLAG, 8'h01);
      chk(takeCount - base, 0);
      wr(OFF_ICR, 8'hC0);
      #1 wait_take(n);
      chk(coreCmd.loadAddr, VEC_HIGH);
      wr(OFF_PFLAG, 8'h00);
      wr(OFF_ICR, 8'h00);
      wr(OFF_PPRI, 8'hFF);
      $display("periph gate done");
   endtask

   // Low routine entered, high pin preempts, returns restore high then low
   task automatic t_two_level();
      wr(OFF_RCR, 8'h80);
      wr(OFF_CFG, 8'h42);
      wr(OFF_ICR, 8'hE0);
      @(posedge clk_sys) timerZeroOvf <= 1'b1;
      @(posedge clk_sys) timerZeroOvf <= 1'b0;
      #1 wait_take(n);
      chk(n, 0);
      chk(coreCmd.loadAddr, VEC_LOW);
      rd_chk(OFF_ICR, 8'hA4);
      wr(OFF_ICR, 8'hB0);
      @(posedge clk_sys) extPinZero <= 1'b1;
      #1 wait_take(n);
      chk(coreCmd.loadAddr, VEC_HIGH);
      rd_chk(OFF_ICR, 8'h32);
      rd_chk(OFF_STAT, 8'h03);
      wr(OFF_ICR, 8'h30);
      ret_irq();
      rd_chk(OFF_ICR, 8'hB0);
      ret_irq();
      rd_chk(OFF_ICR, 8'hF0);
      rd_chk(OFF_STAT, 8'h00);
      @(posedge clk_sys) extPinZero <= 1'b0;
      wr(OFF_ICR, 8'h00);
      $display("two level done");
   endtask

   // High peripheral and low timer in the same cycle
   task automatic t_same_cycle();
      wr(OFF_PEN, 8'h01);
      wr(OFF_ICR, 8'hE0);
      base = takeCount;
      @(posedge clk_sys) begin
         timerZeroOvf <= 1'b1;
         periphEvent  <= 8'h01;
      end
      @(posedge clk_sys) begin
         timerZeroOvf <= 1'b0;
         periphEvent  <= 8'h00;
      end
      #1 wait_take(n);
      chk(coreCmd.loadAddr, VEC_HIGH);
      rd_chk(OFF_ICR, 8'h64);
      chk(takeCount - base, 1);
      wr(OFF_PFLAG, 8'h00);
      wr(OFF_ICR, 8'h00);
      wr(OFF_PEN, 8'h00);
      wr(OFF_RCR, 8'h00);
      $display("same cycle done");
   endtask

   // Mismatch keeps setting the flag until the port is read
   task automatic t_port_change();
      wr(OFF_ICR, 8'h08);
      @(posedge clk_sys) upperPortPins <= 4'hA;
      repeat (6) @(posedge clk_sys);
      rd_chk(OFF_ICR, 8'h09);
      wr(OFF_ICR, 8'h08);
      rd_chk(OFF_ICR, 8'h09);
      rd_chk(OFF_PORT, 8'hA0);
      wr(OFF_ICR, 8'h08);
      rd_chk(OFF_ICR, 8'h08);
      $display("port change done");
   endtask

   // ==========================================================================
   // Main sequence and watchdog
   // ==========================================================================
   // Pins held low through reset so no spurious edge follows release
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      busReq = '0;
      timerZeroOvf = 1'b0;
      extPinZero = 1'b0;
      upperPortPins = 4'h0;
      periphEvent = 8'h00;
      retReq = 1'b0;
      mismatches = 0;
      comparisons = 0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset_map();
      t_pin_compat();
      t_poll_flag();
      t_periph_gate();
      t_two_level();
      t_same_cycle();
      t_port_change();
      chk(pushBad, 0);
      close_out();
   end

   // Whole run needs under two hundred cycles; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      close_out();
   end
endmodule // tlip_unit_tb

// >>> logic/tlip_pkg.sv
// Purpose: Shared constants and carriers for the two-level interrupt priority unit.
// Assumes: 8-bit register port, 21-bit program addresses, one 10 MHz instruction clock.
// Notes:   Offsets are indices on the plain register port, not byte addresses.

package tlip_pkg;

   // ==========================================================================
   // Clock and address widths
   // ==========================================================================
   localparam int unsigned CLK_HZ      = 10_000_000;
   localparam int unsigned PC_W        = 21;
   localparam int unsigned ADDR_W      = 4;

   // Interrupt vectors
   localparam logic [20:0] VEC_HIGH    = 21'h000008;
   localparam logic [20:0] VEC_LOW     = 21'h000018;

   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [3:0]  OFF_ICR     = 4'h0;  // interrupt_control_reg
   localparam logic [3:0]  OFF_RCR     = 4'h1;  // reset_control_reg
   localparam logic [3:0]  OFF_CFG     = 4'h2;  // Core source priorities, edge select
   localparam logic [3:0]  OFF_PFLAG   = 4'h3;  // Peripheral flags
   localparam logic [3:0]  OFF_PEN     = 4'h4;  // Peripheral enables
   localparam logic [3:0]  OFF_PPRI    = 4'h5;  // Peripheral priorities
   localparam logic [3:0]  OFF_PORT    = 4'h6;  // change_port_register
   localparam logic [3:0]  OFF_STAT    = 4'h7;  // Service level status

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int unsigned BIT_GIE     = 7;     // global_irq_enable / high_level_global_enable
   localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE    = 6;     // peripheral_irq_enable / low_level_global_enable
   localparam int unsigned BIT_TMR_IE  = 5;
   localparam int unsigned BIT_EXT_IE  = 4;
   localparam int unsigned BIT_PORT_IE = 3;
   localparam int unsigned BIT_TMR_IF  = 2;
   localparam int unsigned BIT_EXT_IF  = 1;
   localparam int unsigned BIT_PORT_IF = 0;
   localparam int unsigned BIT_PRIORITY_LEVELS_ENABLE    = 7;     // priority_levels_enable in reset_control_reg
   localparam int unsigned BIT_EDGE    = 6;     // Ext pin zero edge: 1 rising, 0 falling

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [7:0]  RST_ICR     = 8'h00;
   localparam logic [7:0]  RST_RCR     = 8'h00;
   localparam logic [7:0]  RST_CFG     = 8'h47;
   localparam logic [7:0]  RST_PPRI    = 8'hFF;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wrData;
      logic       wr;
      logic       rd;
   } tlip_bus_s;

   // Vectoring command to the core
   typedef struct packed {
      logic        push;
      logic [20:0] pushAddr;
      logic        load;
      logic [20:0] loadAddr;
   } tlip_core_s;

endpackage

// >>> logic/tlip_unit.sv
// Purpose: Interrupt flags, enables, priorities and vectoring for an 8-bit core.
// Assumes: Core takes a vector command in any cycle and discards the instruction in flight.
// Notes:   Pins pass three flops; core timer and peripheral events are same-clock pulses.

`timescale 1ns/1ns

// Contract
// - High vector 000008h, low vector 000018h
// - High interrupt preempts running low routine
// - Each source has flag, enable, priority
// - Priority levels only when enable bit set
// - High global enable gates high sources
// - Low global enable gates low sources
// - Vector at once when all enables set
// - Compatibility mode: priority ignored, one vector
// - Taking interrupt clears governing global enable
// - Push return address, load vector
// - Return instruction restores cleared global enable
// - Pin events vector in three-four cycles
// - Flags set regardless of any enable
// - Bit 7 global or high enable
// - Bit 6 peripheral or low enable
// - Bits 5-3 enable timer, pin, port
// - Bit 2 timer overflow flag, sticky
// - Bit 1 ext pin flag, sticky
// - Bit 0 port change, mismatch keeps setting
module tlip_unit
   import tlip_pkg::*;
#(
   parameter int unsigned NPERIPH = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire tlip_bus_s         busReq,
   output logic [7:0]             rdData,
   input  wire logic              timerZeroOvf,
   input  wire logic              extPinZero,
   input  wire logic [3:0]        upperPortPins,
   input  wire logic [NPERIPH-1:0] periphEvent,
   input  wire logic [20:0]       returnAddr,
   input  wire logic              returnFromIrq,
   output tlip_core_s             coreCmd
);

   // ==========================================================================
   // Registers and internal state
   // ==========================================================================
   logic [7:0]         icr_reg;
   logic [7:0]         rcr_reg;
   logic [7:0]         cfg_reg;
   logic [NPERIPH-1:0] pFlag_reg;
   logic [NPERIPH-1:0] pEn_reg;
   logic [NPERIPH-1:0] pPri_reg;
   logic [3:0]         portLatch_reg;
   logic               inHigh_reg;
   logic               inLow_reg;
   logic [4:0]         syncA_reg;
   logic [4:0]         syncB_reg;
   logic [4:0]         syncC_reg;
   logic [4:0]         stable_reg;

   logic [4:0]         agree;
   logic               extEvt;
   logic               portMismatch;
   logic [2:0]         coreSet;
   logic [2:0]         coreFlagEff;
   logic [NPERIPH-1:0] pFlagEff;
   logic               priority_levels_enable;
   logic               compatReq;
   logic               hiReq;
   logic               loReq;
   logic               take;
   logic               takeHigh;
   logic [20:0]        vecSel;
   logic               wrIcr;
   logic               rdPort;

   // Request test shared by core and peripheral groups, for either level
   function automatic logic srcReq(input logic [7:0] f,
                                   input logic [7:0] e,
                                   input logic [7:0] p,
                                   input logic       hi);
      srcReq = |(f & e & (hi ? p : ~p));
   endfunction

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   // Bit 4 is ext pin zero, bits 3:0 the upper port pins; first stage feeds only the second
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         syncA_reg <= 5'h00;
         syncB_reg <= 5'h00;
         syncC_reg <= 5'h00;
      end else begin
         syncA_reg <= {extPinZero, upperPortPins};
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
      end
   end

   // A pin level counts once the second and third stages agree
   assign agree = ~(syncB_reg ^ syncC_reg);

   // Filtered pin levels; pins held high through reset give one event after release
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stable_reg <= 5'h00;
      end else begin
         stable_reg <= (agree & syncC_reg) | (~agree & stable_reg);
      end
   end

   // Edge on ext pin zero in the selected direction
   assign extEvt = agree[4] && (syncC_reg[4] != stable_reg[4]) &&
                   (syncC_reg[4] == cfg_reg[BIT_EDGE]);

   // Mismatch against the value last latched by a port read persists until read
   assign portMismatch = (stable_reg[3:0] != portLatch_reg);

   assign rdPort = busReq.rd && (busReq.addr == OFF_PORT);

   // Latch pins on each port read, ending the mismatch
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         portLatch_reg <= 4'h0;
      end else if (rdPort) begin
         portLatch_reg <= stable_reg[3:0];
      end
   end

   // ==========================================================================
   // Event set terms
   // ==========================================================================
   // Flags set with no regard to enables so software can poll them
   assign coreSet = {timerZeroOvf, extEvt, portMismatch};
   assign coreFlagEff = icr_reg[2:0] | coreSet;
   assign pFlagEff    = pFlag_reg | periphEvent;

   // ==========================================================================
   // Request arbitration
   // ==========================================================================
   assign priority_levels_enable = rcr_reg[BIT_PRIORITY_LEVELS_ENABLE];

   // Compatibility mode: priorities ignored, peripheral group under its own enable
   assign compatReq = icr_reg[BIT_GIE] &&
                      ((|(coreFlagEff & icr_reg[5:3])) ||
                       (icr_reg[BIT_PERIPHERAL_IRQ_ENABLE] && (|(pFlagEff & pEn_reg))));

   // Priority mode: high gated by bit 7, low by both bits so low never preempts high
   assign hiReq = priority_levels_enable && icr_reg[BIT_GIE] &&
                  (srcReq(8'(coreFlagEff), 8'(icr_reg[5:3]), 8'(cfg_reg[2:0]), 1'b1) ||
                   srcReq(8'(pFlagEff), 8'(pEn_reg), 8'(pPri_reg), 1'b1));
   assign loReq = priority_levels_enable && icr_reg[BIT_GIE] && icr_reg[BIT_PERIPHERAL_IRQ_ENABLE] &&
                  (srcReq(8'(coreFlagEff), 8'(icr_reg[5:3]), 8'(cfg_reg[2:0]), 1'b0) ||
                   srcReq(8'(pFlagEff), 8'(pEn_reg), 8'(pPri_reg), 1'b0));

   // High wins a tie; a low routine keeps bit 7 set so high can still enter
   assign takeHigh = priority_levels_enable ? hiReq : compatReq;
   assign take     = takeHigh || loReq;
   assign vecSel   = takeHigh ? VEC_HIGH : VEC_LOW;

   assign wrIcr = busReq.wr && (busReq.addr == OFF_ICR);

   // ==========================================================================
   // Interrupt control register
   // ==========================================================================
   // Flag sets win over a software clear in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         icr_reg[2:0] <= RST_ICR[2:0];
      end else if (wrIcr) begin
         icr_reg[2:0] <= busReq.wrData[2:0] | coreSet;
      end else begin
         icr_reg[2:0] <= coreFlagEff;
      end
   end

   // Source enables are plain software bits
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         icr_reg[5:3] <= RST_ICR[5:3];
      end else if (wrIcr) begin
         icr_reg[5:3] <= busReq.wrData[5:3];
      end
   end

   // Global enables: write, then return restores, then entry clears
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         icr_reg[7:6] <= RST_ICR[7:6];
      end else begin
         if (wrIcr) begin
            icr_reg[7:6] <= busReq.wrData[7:6];
         end
         if (returnFromIrq) begin
            if (!priority_levels_enable || inHigh_reg) begin
               icr_reg[BIT_GIE] <= 1'b1;
            end else if (inLow_reg) begin
               icr_reg[BIT_PERIPHERAL_IRQ_ENABLE] <= 1'b1;
            end
         end
         if (take) begin
            if (takeHigh) begin
               icr_reg[BIT_GIE] <= 1'b0;
            end else begin
               icr_reg[BIT_PERIPHERAL_IRQ_ENABLE] <= 1'b0;
            end
         end
      end
   end

   // Service level tracking steers which enable the return restores
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         inHigh_reg <= 1'b0;
         inLow_reg  <= 1'b0;
      end else begin
         if (returnFromIrq) begin
            if (inHigh_reg) begin
               inHigh_reg <= 1'b0;
            end else begin
               inLow_reg <= 1'b0;
            end
         end
         if (take && takeHigh) begin
            inHigh_reg <= 1'b1;
         end
         if (take && !takeHigh) begin
            inLow_reg <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Other software registers
   // ==========================================================================
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rcr_reg <= RST_RCR;
         cfg_reg <= RST_CFG;
      end else if (busReq.wr) begin
         if (busReq.addr == OFF_RCR) begin
            rcr_reg <= busReq.wrData & 8'h80;
         end
         if (busReq.addr == OFF_CFG) begin
            cfg_reg <= busReq.wrData & 8'h47;
         end
      end
   end

   // Peripheral enables and priorities
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pEn_reg  <= '0;
         pPri_reg <= RST_PPRI[NPERIPH-1:0];
      end else if (busReq.wr) begin
         if (busReq.addr == OFF_PEN) begin
            pEn_reg <= busReq.wrData[NPERIPH-1:0];
         end
         if (busReq.addr == OFF_PPRI) begin
            pPri_reg <= busReq.wrData[NPERIPH-1:0];
         end
      end
   end

   // Peripheral flags; an event beats a software clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pFlag_reg <= '0;
      end else if (busReq.wr && busReq.addr == OFF_PFLAG) begin
         pFlag_reg <= busReq.wrData[NPERIPH-1:0] | periphEvent;
      end else begin
         pFlag_reg <= pFlagEff;
      end
   end

   // ==========================================================================
   // Read port
   // ==========================================================================
   // Unmapped offsets read zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdData <= 8'h00;
      end else if (busReq.rd) begin
         unique case (busReq.addr)
            OFF_ICR:   rdData <= icr_reg;
            OFF_RCR:   rdData <= rcr_reg;
            OFF_CFG:   rdData <= cfg_reg;
            OFF_PFLAG: rdData <= 8'(pFlag_reg);
            OFF_PEN:   rdData <= 8'(pEn_reg);
            OFF_PPRI:  rdData <= 8'(pPri_reg);
            OFF_PORT:  rdData <= {stable_reg[3:0], 4'h0};
            OFF_STAT:  rdData <= {6'h00, inLow_reg, inHigh_reg};
            default:   rdData <= 8'h00;
         endcase
      end else begin
         rdData <= 8'h00;
      end
   end

   // ==========================================================================
   // Vectoring command
   // ==========================================================================
   // One-cycle push and load, taken the cycle after the request is seen
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         coreCmd <= '0;
      end else begin
         coreCmd.push     <= take;
         coreCmd.load     <= take;
         if (take) begin
            coreCmd.pushAddr <= returnAddr;
            coreCmd.loadAddr <= vecSel;
         end
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence enterHigh;
      coreCmd.load && coreCmd.push && (coreCmd.loadAddr == VEC_HIGH);
   endsequence

   sequence enterLow;
      coreCmd.load && coreCmd.push && (coreCmd.loadAddr == VEC_LOW);
   endsequence

   sequence extArmed;
      extEvt && icr_reg[BIT_GIE] && icr_reg[BIT_EXT_IE] && !priority_levels_enable;
   endsequence

   high_vector_a: assert property (hiReq |=> enterHigh)
      else $error("high request did not load high vector");

   low_vector_a: assert property (loReq && !hiReq |=> enterLow)
      else $error("low request did not load low vector");

   compat_vector_a: assert property (!priority_levels_enable && compatReq |=> enterHigh)
      else $error("compatibility mode used wrong vector");

   push_return_a: assert property (take |=> coreCmd.pushAddr == $past(returnAddr))
      else $error("pushed address is not the return address");

   entry_clear_a: assert property (take && takeHigh |=> !icr_reg[BIT_GIE] && inHigh_reg)
      else $error("global enable not cleared on high entry");

   preempt_low_a: assert property (inLow_reg && hiReq && !returnFromIrq |=> enterHigh ##1 !coreCmd.load)
      else $error("high interrupt failed to preempt low routine");

   return_restore_a: assert property (returnFromIrq && priority_levels_enable && inHigh_reg && !take |=> icr_reg[BIT_GIE])
      else $error("return did not restore high enable");

   gate_closed_a: assert property (!icr_reg[BIT_GIE] |=> !coreCmd.load)
      else $error("vectored with global enable clear");

   ext_latency_a: assert property (extArmed |=> enterHigh)
      else $error("ext pin event did not vector in time");

   timer_flag_a: assert property (timerZeroOvf |=> icr_reg[BIT_TMR_IF])
      else $error("timer overflow flag not set");

   port_flag_a: assert property (portMismatch ##1 portMismatch |-> icr_reg[BIT_PORT_IF] ##1 icr_reg[BIT_PORT_IF])
      else $error("port mismatch did not keep flag set");

endmodule // tlip_unit
